// ---- rtl/pp_first_serial_unit_cfg.v ----
// Purpose: config bank for parallel port and first serial unit
// Assumes: register port on core_clk; nack arrives from a pin
// Notes:   reset wins over ce; ce low freezes everything else
//
// Design decision made here: the address-and-strobe port.
`include "pp_uart_cfg_defines.vh"

module pp_first_serial_unit_cfg
(
    // clock, reset, enable
    input  wire       core_clk,
    input  wire       rst,
    input  wire       ce,
    // register port
    input  wire [7:0] reg_ldn,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // parallel port side
    input  wire       nack_pin,
    input  wire       pp_event,
    input  wire       ecp_fifo_active,
    output wire       pp_irq_o,
    output wire       pp_irq_oe,
    output reg        pp_printer_en,
    output reg        pp_spp_en,
    output reg        pp_epp_en,
    output reg        pp_epp_v17,
    output reg        pp_ecp_en,
    output reg  [3:0] ecp_fifo_threshold,
    // floppy routing
    output reg        port_pins_normal,
    output reg        one_drive_on_port_pins,
    output reg        both_drives_on_port_pins,
    // serial units
    input  wire       first_serial_unit_int,
    input  wire       second_serial_unit_int,
    output reg        midi_en,
    output reg        high_speed_en,
    output reg        first_serial_unit_irq,
    output reg        second_serial_unit_irq,
    // summary interrupt
    output reg        irq
);

    // ----------------------------------------
    // mode classes
    // ----------------------------------------
    localparam [2:0] CLS_PRINTER   = 3'h0;
    localparam [2:0] CLS_SPP       = 3'h1;
    localparam [2:0] CLS_EPP19     = 3'h2;
    localparam [2:0] CLS_EPP17     = 3'h3;
    localparam [2:0] CLS_ECP       = 3'h4;
    localparam [2:0] CLS_ECP_EPP19 = 3'h5;
    localparam [2:0] CLS_ECP_EPP17 = 3'h6;
    localparam [7:0] MODE_RST      = `PP_MODE_RST;

    // undefined code 110 falls back to printer, the reset mode
    function [2:0] mode_class;
        input [2:0] code;
        begin
            case (code)
                `PPM_PRINTER:   mode_class = CLS_PRINTER;
                `PPM_SPP:       mode_class = CLS_SPP;
                `PPM_EPP19:     mode_class = CLS_EPP19;
                `PPM_EPP17:     mode_class = CLS_EPP17;
                `PPM_ECP:       mode_class = CLS_ECP;
                `PPM_ECP_EPP19: mode_class = CLS_ECP_EPP19;
                `PPM_ECP_EPP17: mode_class = CLS_ECP_EPP17;
                default:        mode_class = CLS_PRINTER;
            endcase
        end
    endfunction

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg  [7:0]        pp_mode_q;
    reg  [7:0]        pp_share_q;
    reg  [7:0]        ser1_mode_q;
    reg  [`INT_W-1:0] int_stat_q;
    reg  [`INT_W-1:0] int_en_q;
    reg  [`INT_W-1:0] event_prev_q;
    reg               nack_meta_q;
    reg               nack_sync_q;
    reg  [1:0]        irq_style_d;
    reg  [7:0]        rdata_d;

    wire              sel_pp;
    wire              sel_ser1;
    wire              wr_pp_mode;
    wire              wr_pp_share;
    wire              wr_ser1_mode;
    wire              wr_int_clr;
    wire              wr_int_en;
    wire [2:0]        cur_class;
    wire [2:0]        cur_class_d;
    wire [`INT_W-1:0] event_now;
    wire [`INT_W-1:0] event_rise;
    wire [`INT_W-1:0] clr_bits;

    assign sel_pp       = (reg_ldn == `LDN_PP);
    assign sel_ser1     = (reg_ldn == `LDN_SER1);
    assign wr_pp_mode   = reg_wr & sel_pp & (reg_addr == `REG_PP_MODE);
    assign wr_pp_share  = reg_wr & sel_pp & (reg_addr == `REG_PP_SHARE);
    assign wr_ser1_mode = reg_wr & sel_ser1 & (reg_addr == `REG_SER1_MODE);
    assign wr_int_clr   = reg_wr & sel_pp & (reg_addr == `REG_INT_CLR);
    assign wr_int_en    = reg_wr & sel_pp & (reg_addr == `REG_INT_EN);

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            pp_mode_q   <= `PP_MODE_RST;
            pp_share_q  <= `PP_SHARE_RST;
            ser1_mode_q <= `SER1_MODE_RST;
            int_en_q    <= {`INT_W{1'b0}};
        end
        else if (ce)
        begin
            if (wr_pp_mode)
                pp_mode_q <= reg_wdata;
            // reserved bits are dropped so they always read zero
            if (wr_pp_share)
                pp_share_q <= reg_wdata & `PP_SHARE_WMASK;
            if (wr_ser1_mode)
                ser1_mode_q <= reg_wdata & `SER1_WMASK;
            if (wr_int_en)
                int_en_q <= reg_wdata[`INT_W-1:0];
        end
    end

    // ----------------------------------------
    // nack synchroniser
    // ----------------------------------------
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            nack_meta_q <= 1'b1;
            nack_sync_q <= 1'b1;
        end
        else if (ce)
        begin
            nack_meta_q <= nack_pin;
            nack_sync_q <= nack_meta_q;
        end
    end

    // ----------------------------------------
    // parallel port interrupt style
    // ----------------------------------------
    assign cur_class = mode_class(pp_mode_q[`PP_MODE_MSB:`PP_MODE_LSB]);

    always @*
    begin
        irq_style_d = `IRQ_STYLE_NACK;
        case (cur_class)
            CLS_PRINTER,
            CLS_SPP:
                irq_style_d = `IRQ_STYLE_NACK;
            CLS_EPP19,
            CLS_EPP17:
            begin
                if (pp_mode_q[`PP_ITYPE_BIT])
                    irq_style_d = `IRQ_STYLE_PULSE;
                else
                    irq_style_d = `IRQ_STYLE_NACK;
            end
            CLS_ECP,
            CLS_ECP_EPP19,
            CLS_ECP_EPP17:
            begin
                // fifo-type sub-modes override the type bit
                if (ecp_fifo_active)
                    irq_style_d = `IRQ_STYLE_LEVEL;
                else if (pp_mode_q[`PP_ITYPE_BIT])
                    irq_style_d = `IRQ_STYLE_PULSE;
                else
                    irq_style_d = `IRQ_STYLE_NACK;
            end
            default:
                irq_style_d = `IRQ_STYLE_NACK;
        endcase
    end

    pp_irq_shaper u_shaper
    (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .style    (irq_style_d),
        .nack_s   (nack_sync_q),
        .pp_event (pp_event),
        .irq_o    (pp_irq_o),
        .irq_oe   (pp_irq_oe)
    );

    // ----------------------------------------
    // decoded outputs
    // ----------------------------------------
    // registered copy of the write path keeps outputs flop-driven
    assign cur_class_d = wr_pp_mode ?
                         mode_class(reg_wdata[`PP_MODE_MSB:`PP_MODE_LSB]) : cur_class;

    always @(posedge core_clk)
    begin
        if (rst)
        begin
            pp_printer_en            <= 1'b1;
            pp_spp_en                <= 1'b0;
            pp_epp_en                <= 1'b0;
            pp_epp_v17               <= 1'b0;
            pp_ecp_en                <= 1'b0;
            ecp_fifo_threshold       <= MODE_RST[`PP_THR_MSB:`PP_THR_LSB];
            port_pins_normal         <= 1'b1;
            one_drive_on_port_pins   <= 1'b0;
            both_drives_on_port_pins <= 1'b0;
            midi_en                  <= 1'b0;
            high_speed_en            <= 1'b0;
        end
        else if (ce)
        begin
            pp_printer_en <= (cur_class_d == CLS_PRINTER);
            pp_spp_en     <= (cur_class_d != CLS_PRINTER) &&
                             (cur_class_d != CLS_ECP);
            pp_epp_en     <= (cur_class_d == CLS_EPP19) || (cur_class_d == CLS_EPP17) ||
                             (cur_class_d == CLS_ECP_EPP19) ||
                             (cur_class_d == CLS_ECP_EPP17);
            pp_epp_v17    <= (cur_class_d == CLS_EPP17) ||
                             (cur_class_d == CLS_ECP_EPP17);
            pp_ecp_en     <= (cur_class_d == CLS_ECP) || (cur_class_d == CLS_ECP_EPP19) ||
                             (cur_class_d == CLS_ECP_EPP17);
            ecp_fifo_threshold <= wr_pp_mode ? reg_wdata[`PP_THR_MSB:`PP_THR_LSB] :
                                  pp_mode_q[`PP_THR_MSB:`PP_THR_LSB];
            case (pp_share_q[`SHARE_SEL_MSB:`SHARE_SEL_LSB])
                `SHR_ONE_DRIVE:
                begin
                    port_pins_normal         <= 1'b0;
                    one_drive_on_port_pins   <= 1'b1;
                    both_drives_on_port_pins <= 1'b0;
                end
                `SHR_BOTH_DRIVES:
                begin
                    port_pins_normal         <= 1'b0;
                    one_drive_on_port_pins   <= 1'b0;
                    both_drives_on_port_pins <= 1'b1;
                end
                default:
                begin
                    // 00 and the undefined 11 both mean a plain port
                    port_pins_normal         <= 1'b1;
                    one_drive_on_port_pins   <= 1'b0;
                    both_drives_on_port_pins <= 1'b0;
                end
            endcase
            midi_en       <= ser1_mode_q[`SER_MIDI_BIT];
            high_speed_en <= ser1_mode_q[`SER_HS_BIT];
        end
    end

    // ----------------------------------------
    // serial request sharing
    // ----------------------------------------
    // if software left both requests assigned, both lines fire
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            first_serial_unit_irq  <= 1'b0;
            second_serial_unit_irq <= 1'b0;
        end
        else if (ce)
        begin
            if (ser1_mode_q[`SER_SHARE_BIT])
            begin
                first_serial_unit_irq  <= first_serial_unit_int |
                                          second_serial_unit_int;
                second_serial_unit_irq <= first_serial_unit_int |
                                          second_serial_unit_int;
            end
            else
            begin
                first_serial_unit_irq  <= first_serial_unit_int;
                second_serial_unit_irq <= second_serial_unit_int;
            end
        end
    end

    // ----------------------------------------
    // sticky event status
    // ----------------------------------------
    assign event_now[`INT_PP_BIT]   = pp_event;
    assign event_now[`INT_SER1_BIT] = first_serial_unit_int;
    assign event_now[`INT_SER2_BIT] = second_serial_unit_int;
    assign event_rise               = event_now & ~event_prev_q;
    assign clr_bits                 = wr_int_clr ? reg_wdata[`INT_W-1:0] : {`INT_W{1'b0}};

    genvar gi;
    generate
        for (gi = 0; gi < `INT_W; gi = gi + 1)
        begin : g_stat
            always @(posedge core_clk)
            begin
                if (rst)
                begin
                    event_prev_q[gi] <= 1'b0;
                    int_stat_q[gi]   <= 1'b0;
                end
                else if (ce)
                begin
                    event_prev_q[gi] <= event_now[gi];
                    // a new event beats a clear in the same cycle
                    if (event_rise[gi])
                        int_stat_q[gi] <= 1'b1;
                    else if (clr_bits[gi])
                        int_stat_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always @(posedge core_clk)
    begin
        if (rst)
            irq <= 1'b0;
        else if (ce)
            irq <= |(int_stat_q & int_en_q);
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    always @*
    begin
        rdata_d = 8'h00;
        if (sel_pp)
        begin
            case (reg_addr)
                `REG_PP_MODE:  rdata_d = pp_mode_q;
                `REG_PP_SHARE: rdata_d = pp_share_q;
                `REG_INT_STAT: rdata_d = {{(8-`INT_W){1'b0}}, int_stat_q};
                `REG_INT_EN:   rdata_d = {{(8-`INT_W){1'b0}}, int_en_q};
                default:       rdata_d = 8'h00;
            endcase
        end
        else if (sel_ser1)
        begin
            case (reg_addr)
                `REG_SER1_MODE: rdata_d = ser1_mode_q;
                default:        rdata_d = 8'h00;
            endcase
        end
    end

    // data stand one cycle after the strobe, for as many cycles as it is held
    always @(posedge core_clk)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (ce)
            reg_rdata <= reg_rd ? rdata_d : 8'h00;
    end

endmodule

// ---- rtl/pp_irq_shaper.v ----
// Purpose: shape the parallel port interrupt request pin
// Assumes: nack_s already synchronised, pp_event on core_clk
// Notes:   pin is open style in pulse mode, driven otherwise
`include "pp_uart_cfg_defines.vh"

module pp_irq_shaper
(
    // clock and reset
    input  wire       core_clk,
    input  wire       rst,
    input  wire       ce,
    // control
    input  wire [1:0] style,
    input  wire       nack_s,
    input  wire       pp_event,
    // request pin
    output reg        irq_o,
    output reg        irq_oe
);

    reg                      event_prev_q;
    reg [`PULSE_CNT_W-1:0]   pulse_cnt_q;
    wire                     event_rise;
    localparam [31:0]        PULSE_LD = `PP_PULSE_CYC;

    assign event_rise = pp_event & ~event_prev_q;

    // ----------------------------------------
    // pulse timer
    // ----------------------------------------
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            event_prev_q <= 1'b0;
            pulse_cnt_q  <= {`PULSE_CNT_W{1'b0}};
        end
        else if (ce)
        begin
            event_prev_q <= pp_event;
            if (style != `IRQ_STYLE_PULSE)
                pulse_cnt_q <= {`PULSE_CNT_W{1'b0}};
            else if (event_rise)
                pulse_cnt_q <= PULSE_LD[`PULSE_CNT_W-1:0];
            else if (pulse_cnt_q != {`PULSE_CNT_W{1'b0}})
                pulse_cnt_q <= pulse_cnt_q - 1'b1;
        end
    end

    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            irq_o  <= 1'b0;
            irq_oe <= 1'b0;
        end
        else if (ce)
        begin
            case (style)
                `IRQ_STYLE_PULSE:
                begin
                    // low while timing, else released to the pull-up
                    irq_o  <= 1'b0;
                    irq_oe <= (pulse_cnt_q != {`PULSE_CNT_W{1'b0}}) | event_rise;
                end
                `IRQ_STYLE_LEVEL:
                begin
                    irq_o  <= pp_event;
                    irq_oe <= 1'b1;
                end
                default:
                begin
                    irq_o  <= nack_s;
                    irq_oe <= 1'b1;
                end
            endcase
        end
    end

endmodule

// ---- shared/pp_uart_cfg_defines.vh ----
// Purpose: constants for the parallel port / first serial unit config bank
// Assumes: included by bare name from every design file
// Notes:   registers are addressed by logical device number plus index
`ifndef PP_UART_CFG_DEFINES_VH
`define PP_UART_CFG_DEFINES_VH

// ----------------------------------------
// logical devices and register indices
// ----------------------------------------
`define LDN_PP             8'h03
`define LDN_SER1           8'h04
`define REG_PP_MODE        8'hf0
`define REG_PP_SHARE       8'hf1
`define REG_SER1_MODE      8'hf0
`define REG_INT_STAT       8'hf8
`define REG_INT_CLR        8'hf9
`define REG_INT_EN         8'hfa

// ----------------------------------------
// reset values and write masks
// ----------------------------------------
`define PP_MODE_RST        8'h3c
`define PP_SHARE_RST       8'h00
`define SER1_MODE_RST      8'h00
`define PP_SHARE_WMASK     8'h03
`define SER1_WMASK         8'h83

// ----------------------------------------
// field positions
// ----------------------------------------
`define PP_MODE_MSB        2
`define PP_MODE_LSB        0
`define PP_THR_MSB         6
`define PP_THR_LSB         3
`define PP_ITYPE_BIT       7
`define SHARE_SEL_MSB      1
`define SHARE_SEL_LSB      0
`define SER_MIDI_BIT       0
`define SER_HS_BIT         1
`define SER_SHARE_BIT      7

// ----------------------------------------
// port mode encodings
// ----------------------------------------
`define PPM_PRINTER        3'h4
`define PPM_SPP            3'h0
`define PPM_EPP19          3'h1
`define PPM_EPP17          3'h5
`define PPM_ECP            3'h2
`define PPM_ECP_EPP19      3'h3
`define PPM_ECP_EPP17      3'h7

// ----------------------------------------
// floppy share encodings
// ----------------------------------------
`define SHR_NORMAL         2'h0
`define SHR_ONE_DRIVE      2'h1
`define SHR_BOTH_DRIVES    2'h2

// ----------------------------------------
// interrupt request styles
// ----------------------------------------
`define IRQ_STYLE_NACK     2'h0
`define IRQ_STYLE_PULSE    2'h1
`define IRQ_STYLE_LEVEL    2'h2

// ----------------------------------------
// interrupt status layout
// ----------------------------------------
`define INT_W              3
`define INT_PP_BIT         0
`define INT_SER1_BIT       1
`define INT_SER2_BIT       2

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS      8
`define PP_PULSE_NS        1000
`define PP_PULSE_CYC       ((`PP_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_CNT_W        8

`endif

// ---- verification/pp_first_serial_unit_cfg_monitor.sv ----
// Purpose: watch the config bank ports for rule breaks
// Assumes: ce held high; mirrors copy register writes on their own
// Notes:   mirrors never look inside the design
module pp_first_serial_unit_cfg_monitor
(
    // clock and reset
    input logic       core_clk,
    input logic       rst,
    input logic       ce,
    // register port
    input logic [7:0] reg_ldn,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic       reg_wr,
    // parallel port
    input logic       nack_pin,
    input logic       pp_event,
    input logic       ecp_fifo_active,
    input logic       pp_irq_o,
    input logic       pp_irq_oe,
    input logic       pp_printer_en,
    input logic       pp_ecp_en,
    input logic [3:0] ecp_fifo_threshold,
    // routing and serial units
    input logic       port_pins_normal,
    input logic       one_drive_on_port_pins,
    input logic       both_drives_on_port_pins,
    input logic       first_serial_unit_int,
    input logic       second_serial_unit_int,
    input logic       midi_en,
    input logic       high_speed_en,
    input logic       first_serial_unit_irq,
    input logic       second_serial_unit_irq
);
    logic [7:0] mode_q;
    logic [1:0] share_q;
    logic [7:0] ser_q;
    logic [2:0] live_q;
    logic [2:0] m;
    logic [2:0] route_exp;
    logic       wr_pp;
    logic       ecp_cls;
    logic       nack_cls;
    assign m = mode_q[2:0];
    assign wr_pp = reg_wr && ce && reg_ldn == 8'h03;
    assign ecp_cls = m == 3'h2 || m == 3'h3 || m == 3'h7;
    // type bit only counts for the epp codes
    assign nack_cls = (!m[1] && (!m[0] || !mode_q[7])) || m == 3'h6;
    assign route_exp = share_q == 2'h1 ? 3'b010 : share_q == 2'h2 ? 3'b001 : 3'b100;
    always @(posedge core_clk)
    begin
        live_q <= rst ? 3'h0 : live_q + {2'h0, live_q != 3'h7};
        if (rst)
            mode_q <= 8'h3c;
        else if (wr_pp && reg_addr == 8'hf0)
            mode_q <= reg_wdata;
        if (rst)
            share_q <= 2'h0;
        else if (wr_pp && reg_addr == 8'hf1)
            share_q <= reg_wdata[1:0];
        if (rst)
            ser_q <= 8'h00;
        else if (reg_wr && ce && reg_ldn == 8'h04 && reg_addr == 8'hf0)
            ser_q <= reg_wdata & 8'h83;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_mode_decode: assert property (pp_printer_en == (m == 3'h4 || m == 3'h6) && pp_ecp_en == ecp_cls)
        else $error("decoded mode differs from mode field");
    chk_fifo_thr: assert property (ecp_fifo_threshold == mode_q[6:3])
        else $error("fifo threshold differs from mode bits");
    chk_drive_route: assert property (!$past(rst) |-> {port_pins_normal, one_drive_on_port_pins, both_drives_on_port_pins} == $past(route_exp))
        else $error("floppy routing differs from share select");
    chk_serial_bits: assert property (!$past(rst) |-> {midi_en, high_speed_en} == {$past(ser_q[0]), $past(ser_q[1])})
        else $error("serial mode outputs differ from register");
    chk_share_both: assert property (!$past(rst) && $past(ser_q[7]) |-> first_serial_unit_irq == $past(first_serial_unit_int || second_serial_unit_int) && second_serial_unit_irq == first_serial_unit_irq)
        else $error("shared request not raised on both units");
    chk_own_request: assert property (!$past(rst) && !$past(ser_q[7]) |-> first_serial_unit_irq == $past(first_serial_unit_int) && second_serial_unit_irq == $past(second_serial_unit_int))
        else $error("separate request does not follow own unit");
    chk_pulse_release: assert property ($fell(pp_irq_oe) && mode_q == $past(mode_q, 3) |-> !$past(pp_irq_o))
        else $error("pin released without a low pulse");
    chk_level_ecp: assert property (!$past(rst) && $past(ecp_cls && ecp_fifo_active) && $past(ecp_cls, 2) |-> pp_irq_oe && pp_irq_o == $past(pp_event))
        else $error("level request does not follow event");
    chk_nack_follow: assert property (live_q == 3'h7 && nack_cls && $past(nack_cls) && $past(nack_cls, 2) && $past(nack_cls, 3) |-> pp_irq_oe && pp_irq_o == $past(nack_pin, 3))
        else $error("request does not follow acknowledge pin");
endmodule

bind pp_first_serial_unit_cfg pp_first_serial_unit_cfg_monitor chk_u (.*);

// ---- verification/test_pp_first_serial_unit_cfg.sv ----
// Purpose: self-checking bench for the config bank
// Assumes: ce tied high; pulse width taken from the shared header
// Notes:   table rows first, then pin and interrupt cases
`include "pp_uart_cfg_defines.vh"
module test_pp_first_serial_unit_cfg;
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  reg_ldn, reg_addr, reg_wdata, reg_rdata, got;
    logic        core_clk, rst, ce, reg_wr, reg_rd, nack_pin, pp_event, ecp_fifo_active, irq;
    logic        pp_irq_o, pp_irq_oe, pp_printer_en, pp_spp_en, pp_epp_en, pp_epp_v17, pp_ecp_en;
    logic        port_pins_normal, one_drive_on_port_pins, both_drives_on_port_pins;
    logic        first_serial_unit_int, second_serial_unit_int, midi_en, high_speed_en;
    logic        first_serial_unit_irq, second_serial_unit_irq;
    logic [3:0]  ecp_fifo_threshold;
    logic [15:0] outs, o;
    logic [48:0] rows [22];
    int          error_cnt, total_checks, cyc, n;
    pp_first_serial_unit_cfg dut_u (.core_clk, .rst, .ce, .reg_ldn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .nack_pin, .pp_event, .ecp_fifo_active, .pp_irq_o, .pp_irq_oe, .pp_printer_en,
        .pp_spp_en, .pp_epp_en, .pp_epp_v17, .pp_ecp_en, .ecp_fifo_threshold, .port_pins_normal,
        .one_drive_on_port_pins, .both_drives_on_port_pins, .first_serial_unit_int,
        .second_serial_unit_int, .midi_en, .high_speed_en, .first_serial_unit_irq,
        .second_serial_unit_irq, .irq);
    assign outs = {2'h0, ecp_fifo_threshold, pp_printer_en, pp_spp_en, pp_epp_en, pp_epp_v17,
        pp_ecp_en, port_pins_normal, one_drive_on_port_pins, both_drives_on_port_pins, midi_en,
        high_speed_en};
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] l, input logic [7:0] a, input logic [7:0] d);
        reg_ldn <= l;
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // samples mid-cycle, once settled
    task automatic rd(input logic [7:0] l, input logic [7:0] a, output logic [7:0] v,
        output logic [15:0] ov);
        reg_ldn <= l;
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        v = reg_rdata;
        ov = outs;
        @(posedge core_clk);
    endtask
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            error_cnt++;
            close_out();
        end
    end
    initial
    begin
        {reg_ldn, reg_addr, reg_wdata, reg_wr, reg_rd, pp_event, ecp_fifo_active} = 28'h0;
        {first_serial_unit_int, second_serial_unit_int} = 2'h0;
        {nack_pin, ce, rst} = 3'h7;
        // row: write flag, device, index, data, read back, outputs
        rows = '{49'h0_03f0_3c3c_1e10, 49'h0_03f1_0000_1e10, 49'h0_04f0_0000_1e10,
            49'h1_03f0_3838_1d10, 49'h1_03f0_3939_1d90, 49'h1_03f0_3d3d_1dd0,
            49'h1_03f0_3a3a_1c30, 49'h1_03f0_3b3b_1db0, 49'h1_03f0_3f3f_1df0,
            49'h1_03f0_3e3e_1e10, 49'h1_03f0_8484_0210, 49'h1_03f1_0101_0208,
            49'h1_03f1_0202_0204, 49'h1_03f1_0303_0210, 49'h1_04f0_0303_0213,
            49'h1_04f0_8181_0212, 49'h1_04f0_0000_0210, 49'h1_03f8_ff00_0210,
            49'h1_03f5_ff00_0210, 49'h1_06f0_ff00_0210, 49'h1_03f9_0000_0210,
            49'h1_03fa_0707_0210};
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        foreach (rows[i])
        begin
            if (rows[i][48])
                wr(rows[i][47:40], rows[i][39:32], rows[i][31:24]);
            rd(rows[i][47:40], rows[i][39:32], got, o);
            chk("readback", {8'h0, got}, {8'h0, rows[i][23:16]});
            chk("outputs", o, rows[i][15:0]);
        end
        for (int s = 0; s < 2; s++)
        begin
            wr(8'h04, 8'hf0, {s[0], 7'h0});
            second_serial_unit_int <= 1'b1;
            repeat (3) @(posedge core_clk);
            chk("shared", {14'h0, first_serial_unit_irq, second_serial_unit_irq}, {14'h0, s[0], 1'b1});
            second_serial_unit_int <= 1'b0;
            @(posedge core_clk);
        end
        // printer mode, type bit one: pin follows nack
        pp_event <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk("pin", {14'h0, pp_irq_oe, pp_irq_o}, 16'h3);
        chk("irq", {15'h0, irq}, 16'h1);
        rd(8'h03, 8'hf8, got, o);
        chk("status", {8'h0, got}, 16'h5);
        wr(8'h03, 8'hfa, 8'h00);
        repeat (2) @(posedge core_clk);
        chk("masked", {15'h0, irq}, 16'h0);
        wr(8'h03, 8'hf9, 8'h05);
        pp_event <= 1'b0;
        rd(8'h03, 8'hf8, got, o);
        chk("cleared", {8'h0, got}, 16'h0);
        wr(8'h03, 8'hf0, 8'h81);
        repeat (4) @(posedge core_clk);
        pp_event <= 1'b1;
        n = 0;
        repeat (140)
        begin
            @(negedge core_clk);
            n += int'(pp_irq_oe && !pp_irq_o);
        end
        chk("pulse", 16'(n), 16'(`PP_PULSE_CYC + 1));
        chk("release", {15'h0, pp_irq_oe}, 16'h0);
        @(posedge core_clk);
        pp_event <= 1'b0;
        wr(8'h03, 8'hf0, 8'h01);
        nack_pin <= 1'b0;
        repeat (5) @(negedge core_clk);
        chk("follow", {14'h0, pp_irq_oe, pp_irq_o}, 16'h2);
        @(posedge core_clk);
        nack_pin <= 1'b1;
        wr(8'h03, 8'hf0, 8'h82);
        ecp_fifo_active <= 1'b1;
        pp_event <= 1'b1;
        repeat (3) @(negedge core_clk);
        chk("level", {14'h0, pp_irq_oe, pp_irq_o}, 16'h3);
        @(posedge core_clk);
        pp_event <= 1'b0;
        repeat (3) @(negedge core_clk);
        chk("level", {14'h0, pp_irq_oe, pp_irq_o}, 16'h2);
        @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        rd(8'h03, 8'hf0, got, o);
        chk("reset", o, 16'h1e10);
        chk("reset", {8'h0, got}, 16'h3c);
        close_out();
    end
endmodule
